// file: tws_defines.vh
// Register offsets, field positions, reset values and timing counts for the two-wire serial block.
// Assumes inclusion by bare name from the design files.
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH

// ************************************************************
// Register offsets (byte index on the plain register port)
// ************************************************************
`define TWS_OFS_CTRL1   4'h0
`define TWS_OFS_CTRL2   4'h1
`define TWS_OFS_MODE    4'h2
`define TWS_OFS_IRQEN   4'h3
`define TWS_OFS_STATUS  4'h4
`define TWS_OFS_OWNADR  4'h5
`define TWS_OFS_TXHOLD  4'h6
`define TWS_OFS_RXHOLD  4'h7

// ************************************************************
// Field positions
// ************************************************************
`define TWS_C1_ENABLE   7
`define TWS_C1_MASTER   5
`define TWS_C1_TRANSMIT 4
`define TWS_C2_BUSY     7
`define TWS_C2_SSCTRL   6
`define TWS_MODE_ORDER  7
`define TWS_IE_ACKCHK   0
`define TWS_IE_RX_ACK_BIT    1
`define TWS_ST_TXE      7
`define TWS_ST_TX_END_FLAG     6
`define TWS_ST_RXF      5
`define TWS_ST_NACK     4
`define TWS_ST_STOP     3
`define TWS_ST_AAS      1
`define TWS_ST_GC       0

// ************************************************************
// Reset values and timing
// ************************************************************
`define TWS_DATA_RESET  8'hff
`define TWS_GCALL_ADDR  7'h00
`define TWS_CLK_HZ      20000000
`define TWS_SCL_HZ      100000
// Quarter bit in core cycles: core clock over four times bus clock, sized for the 8-bit divider
`define TWS_QTR_CYCLES  8'd50

`endif

// file: tws_sync.v
// Two-flop synchroniser for the open-drain bus inputs.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ps
module tws_sync
(
  input wire core_clk,
  input wire srst,
  input wire din,
  output reg dout
);
  reg meta_q;

  // Bus idles high, so reset to one
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // tws_sync

// file: tws_qdiv.v
// Quarter-bit enable divider for the master clock generator.
// Assumes a single core_clk domain; tick is a one-cycle pulse.
`timescale 1ns/1ps
module tws_qdiv
#(
  parameter CNT_W = 8,
  parameter [CNT_W-1:0] DIV = 8'd50
)
(
  input wire core_clk,
  input wire srst,
  input wire run,
  output reg tick
);
  reg [CNT_W-1:0] cnt_q;

  // Count holds at zero while idle so each phase starts fresh
  always @(posedge core_clk)
  begin
    if (srst || !run)
    begin
      cnt_q <= {CNT_W{1'b0}};
      tick <= 1'b0;
    end
    else if (cnt_q == DIV - 1'b1)
    begin
      cnt_q <= {CNT_W{1'b0}};
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule // tws_qdiv

// file: tws_core.v
// Two-wire serial block: register port, master transmit engine, slave address recognition.
// Assumes open-drain pins resolved outside; strobes are one cycle, read data the cycle after.
// Functional notes
// - Slave receive: first frame matching own address sets address-match flag
// - General call address sets general-call and address-match flags together
// - Those flags clear only by writing 0 after reading them as 1
// - Slave when upper seven address bits equal first frame upper seven bits
// - Own-address bit 0 selects format: 0 two-wire, 1 synchronous; resets 0
// - Transmit holding moves to shifter once free; writes during shift chain
// - Bit-order select 1 reads transmit holding with bit order reversed
// - Transmit and receive holding registers reset to all ones
// - First byte after each start copies shifter to receive holding; CPU writes ignored
// - Shifter drives and collects data bits, never readable by CPU
// - First frame after start is eight bits: address plus direction
// - Start: data falls while clock high
// - Stop: data rises while clock high
// - Direction bit 1 slave-to-master, 0 master-to-slave
// - Receiver acknowledges by holding data low in acknowledge clock
// - Bus free, master transmit, write busy=1 ssctrl=0 issues start
// - Writing transmit holding clears empty, moves byte, then sets empty
// - Byte done with empty set raises transmit-end at ninth clock rise
// - Master transmit holds clock low until new data or stop request
// - Stop detected after master transmit returns to slave receive
// - Stop in master transmit, or before a slave frame completes, sets the stop-detected flag
// - Missing acknowledge with checking enabled sets no-ack flag
`timescale 1ns/1ps
`include "tws_defines.vh"
module tws_core
#(
  parameter [7:0] QTR = `TWS_QTR_CYCLES
)
(
  input wire core_clk,
  input wire srst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire scl_in,
  output reg scl_out,
  output reg scl_oe,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe
);
  // ************************************************************
  // States (one-hot)
  // ************************************************************
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_START = 7'h02;
  localparam [6:0] S_WAIT = 7'h04;
  localparam [6:0] S_BIT = 7'h08;
  localparam [6:0] S_ACK = 7'h10;
  localparam [6:0] S_STOP = 7'h20;
  localparam [6:0] S_HOLD = 7'h40;

  // Bit-order reversal, used for readback and shifting
  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
        rev8[i] = v[7-i];
    end
  endfunction

  reg [7:0] ctrl1_q;
  reg order_q;
  reg ackchk_q;
  reg rx_ack_bit_q;
  reg [7:0] ownadr_q;
  reg [7:0] txhold_q;
  reg [7:0] rxhold_q;
  reg [7:0] shift_q;
  reg txe_q, tx_end_flag_q, rxf_q, nack_q, stop_q, aas_q, gc_q;
  reg [7:0] seen_q;
  reg [6:0] st_q;
  reg [1:0] ph_q;
  reg [3:0] bit_q;
  reg busy_q;
  reg scl_s_q, sda_s_q;
  reg sl_act_q;
  reg sl_ack_q;
  reg [3:0] sl_cnt_q;
  reg [7:0] sl_sh_q;
  reg mst_tx_q;
  wire scl_s, sda_s, qtick;
  wire master = ctrl1_q[`TWS_C1_MASTER];
  wire trans = ctrl1_q[`TWS_C1_TRANSMIT];
  wire fmt_sync = ownadr_q[0];
  wire [7:0] st_word = {txe_q, tx_end_flag_q, rxf_q, nack_q, stop_q, 1'b0, aas_q, gc_q};
  wire wr_tx = reg_wr && reg_addr == `TWS_OFS_TXHOLD;
  wire wr_st = reg_wr && reg_addr == `TWS_OFS_STATUS;
  wire wr_c2 = reg_wr && reg_addr == `TWS_OFS_CTRL2;
  wire start_req = wr_c2 && reg_wdata[`TWS_C2_BUSY] && !reg_wdata[`TWS_C2_SSCTRL];
  wire stop_req = wr_c2 && !reg_wdata[`TWS_C2_BUSY] && !reg_wdata[`TWS_C2_SSCTRL];
  wire scl_rise = scl_s && !scl_s_q;
  wire scl_fall = !scl_s && scl_s_q;
  wire bus_start = scl_s && scl_s_q && sda_s_q && !sda_s;
  wire bus_stop = scl_s && scl_s_q && !sda_s_q && sda_s;
  wire [7:0] tx_bits = order_q ? rev8(shift_q) : shift_q;

  // ************************************************************
  // Input synchronisers and quarter-bit divider
  // ************************************************************
  tws_sync u_scl_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .din(scl_in),
    .dout(scl_s)
  );
  tws_sync u_sda_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .din(sda_in),
    .dout(sda_s)
  );
  tws_qdiv #(.CNT_W(8), .DIV(QTR)) u_qdiv
  (
    .core_clk(core_clk),
    .srst(srst),
    .run(st_q != S_IDLE && st_q != S_WAIT && st_q != S_HOLD),
    .tick(qtick)
  );

  // ************************************************************
  // Register read port
  // ************************************************************
  // Shifter has no read address; it stays internal
  always @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `TWS_OFS_CTRL1: reg_rdata <= ctrl1_q;
        `TWS_OFS_CTRL2: reg_rdata <= {busy_q, 7'h00};
        `TWS_OFS_MODE: reg_rdata <= {order_q, 7'h00};
        `TWS_OFS_IRQEN: reg_rdata <= {6'h00, rx_ack_bit_q, ackchk_q};
        `TWS_OFS_STATUS: reg_rdata <= st_word;
        `TWS_OFS_OWNADR: reg_rdata <= ownadr_q;
        `TWS_OFS_TXHOLD: reg_rdata <= order_q ? rev8(txhold_q) : txhold_q;
        `TWS_OFS_RXHOLD: reg_rdata <= rxhold_q;
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // Remember which status bits software has seen set
  always @(posedge core_clk)
  begin
    if (srst)
      seen_q <= 8'h00;
    else if (reg_rd && reg_addr == `TWS_OFS_STATUS)
      seen_q <= st_word;
    else if (wr_st)
      seen_q <= 8'h00;
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl1_q <= 8'h00;
      order_q <= 1'b0;
      ackchk_q <= 1'b0;
      ownadr_q <= 8'h00;
    end
    else
    begin
      if (reg_wr && reg_addr == `TWS_OFS_CTRL1)
        ctrl1_q <= reg_wdata;
      if (reg_wr && reg_addr == `TWS_OFS_MODE)
        order_q <= reg_wdata[`TWS_MODE_ORDER];
      if (reg_wr && reg_addr == `TWS_OFS_IRQEN)
        ackchk_q <= reg_wdata[`TWS_IE_ACKCHK];
      if (reg_wr && reg_addr == `TWS_OFS_OWNADR)
        ownadr_q <= reg_wdata;
      // Back to slave receive once stop seen after master transmit
      if (mst_tx_q && bus_stop)
        ctrl1_q[`TWS_C1_MASTER] <= 1'b0;
      if (mst_tx_q && bus_stop)
        ctrl1_q[`TWS_C1_TRANSMIT] <= 1'b0;
    end
  end

  // Bus busy follows start and stop seen on the wire
  always @(posedge core_clk)
  begin
    if (srst)
      busy_q <= 1'b0;
    else if (bus_start)
      busy_q <= 1'b1;
    else if (bus_stop)
      busy_q <= 1'b0;
  end

  // ************************************************************
  // Master transmit engine
  // ************************************************************
  // Phases: 0 scl low set data, 1 scl rise, 2 scl high sample, 3 scl fall
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      st_q <= S_IDLE;
      ph_q <= 2'd0;
      bit_q <= 4'd0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      shift_q <= `TWS_DATA_RESET;
      txhold_q <= `TWS_DATA_RESET;
      txe_q <= 1'b0;
      tx_end_flag_q <= 1'b0;
      nack_q <= 1'b0;
      rx_ack_bit_q <= 1'b0;
      mst_tx_q <= 1'b0;
    end
    else
    begin
      if (wr_tx)
      begin
        txhold_q <= reg_wdata;
        txe_q <= 1'b0;
      end
      // Set wins over software clear for each flag
      if (wr_st && seen_q[`TWS_ST_TX_END_FLAG] && !reg_wdata[`TWS_ST_TX_END_FLAG])
        tx_end_flag_q <= 1'b0;
      if (wr_st && seen_q[`TWS_ST_NACK] && !reg_wdata[`TWS_ST_NACK])
        nack_q <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          // Slave acknowledge: data held low from the eighth clock fall to the ninth
          if (scl_fall)
            sda_oe <= sl_ack_q && !sda_oe;
          if (start_req && !busy_q && master && trans && !fmt_sync)
          begin
            st_q <= S_START;
            ph_q <= 2'd0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            mst_tx_q <= 1'b1;
            txe_q <= 1'b1;
          end
        end
        S_START:
        begin
          if (qtick)
          begin
            // Pull data low with clock released high, then clock low
            if (ph_q == 2'd1)
              sda_oe <= 1'b1;
            if (ph_q == 2'd3)
            begin
              scl_oe <= 1'b1;
              st_q <= S_WAIT;
            end
            ph_q <= ph_q + 2'd1;
          end
        end
        S_WAIT:
        begin
          // Clock held low until data arrives or stop requested
          scl_oe <= 1'b1;
          if (stop_req)
          begin
            st_q <= S_STOP;
            ph_q <= 2'd0;
            sda_oe <= 1'b1;
          end
          else if (!txe_q && !wr_tx)
          begin
            shift_q <= txhold_q;
            txe_q <= 1'b1;
            bit_q <= 4'd0;
            ph_q <= 2'd0;
            st_q <= S_BIT;
          end
        end
        S_BIT:
        begin
          if (qtick)
          begin
            if (ph_q == 2'd0)
              sda_oe <= !tx_bits[7 - bit_q[2:0]];
            if (ph_q == 2'd1)
              scl_oe <= 1'b0;
            if (ph_q == 2'd3)
            begin
              scl_oe <= 1'b1;
              if (bit_q == 4'd7)
                st_q <= S_ACK;
              bit_q <= bit_q + 4'd1;
            end
            ph_q <= ph_q + 2'd1;
          end
        end
        S_ACK:
        begin
          if (qtick)
          begin
            if (ph_q == 2'd0)
              sda_oe <= 1'b0;
            if (ph_q == 2'd1)
            begin
              scl_oe <= 1'b0;
              if (txe_q)
                tx_end_flag_q <= 1'b1;
            end
            if (ph_q == 2'd2)
            begin
              rx_ack_bit_q <= sda_s;
              if (sda_s && ackchk_q)
                nack_q <= 1'b1;
            end
            if (ph_q == 2'd3)
            begin
              scl_oe <= 1'b1;
              st_q <= S_WAIT;
            end
            ph_q <= ph_q + 2'd1;
          end
        end
        S_STOP:
        begin
          if (qtick)
          begin
            if (ph_q == 2'd1)
              scl_oe <= 1'b0;
            if (ph_q == 2'd3)
            begin
              sda_oe <= 1'b0;
              st_q <= S_HOLD;
            end
            ph_q <= ph_q + 2'd1;
          end
        end
        S_HOLD:
        begin
          if (bus_stop || !busy_q)
          begin
            st_q <= S_IDLE;
            mst_tx_q <= 1'b0;
          end
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Slave address recognition and receive capture
  // ************************************************************
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      scl_s_q <= 1'b1;
      sda_s_q <= 1'b1;
      sl_act_q <= 1'b0;
      sl_ack_q <= 1'b0;
      sl_cnt_q <= 4'd0;
      sl_sh_q <= 8'h00;
      rxhold_q <= `TWS_DATA_RESET;
      aas_q <= 1'b0;
      gc_q <= 1'b0;
      rxf_q <= 1'b0;
      stop_q <= 1'b0;
    end
    else
    begin
      scl_s_q <= scl_s;
      sda_s_q <= sda_s;
      if (wr_st && seen_q[`TWS_ST_AAS] && !reg_wdata[`TWS_ST_AAS])
        aas_q <= 1'b0;
      if (wr_st && seen_q[`TWS_ST_GC] && !reg_wdata[`TWS_ST_GC])
        gc_q <= 1'b0;
      if (wr_st && seen_q[`TWS_ST_STOP] && !reg_wdata[`TWS_ST_STOP])
        stop_q <= 1'b0;
      if (wr_st && seen_q[`TWS_ST_RXF] && !reg_wdata[`TWS_ST_RXF])
        rxf_q <= 1'b0;
      if (reg_rd && reg_addr == `TWS_OFS_RXHOLD)
        rxf_q <= 1'b0;
      // Acknowledge ends at the ninth clock fall
      if (scl_fall && sda_oe)
        sl_ack_q <= 1'b0;
      if (bus_start)
      begin
        sl_act_q <= 1'b1;
        sl_ack_q <= 1'b0;
        sl_cnt_q <= 4'd0;
      end
      else if (bus_stop)
      begin
        if (sl_act_q || mst_tx_q)
          stop_q <= 1'b1;
        sl_act_q <= 1'b0;
      end
      else if (sl_act_q && scl_rise && sl_cnt_q < 4'd8)
      begin
        sl_sh_q <= {sl_sh_q[6:0], sda_s};
        sl_cnt_q <= sl_cnt_q + 4'd1;
        if (sl_cnt_q == 4'd7)
        begin
          rxhold_q <= {sl_sh_q[6:0], sda_s};
          rxf_q <= 1'b1;
          sl_act_q <= 1'b0;
          if (!master && !trans && !fmt_sync)
          begin
            sl_ack_q <= sl_sh_q[6:0] == ownadr_q[7:1] || sl_sh_q[6:0] == `TWS_GCALL_ADDR;
            // Upper seven bits are address; bit 0 is direction
            if (sl_sh_q[6:0] == ownadr_q[7:1])
              aas_q <= 1'b1;
            if (sl_sh_q[6:0] == `TWS_GCALL_ADDR)
            begin
              aas_q <= 1'b1;
              gc_q <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule // tws_core

// file: tws_core_props.sv
// Checker for tws_core: register port answers and bus pin framing.
// Assumes scl_in and sda_in carry the resolved wire levels.
`timescale 1ns/1ps
`include "tws_defines.vh"
module tws_chk
#(
  parameter [7:0] QTR = `TWS_QTR_CYCLES
)
(
  input wire core_clk,
  input wire srst,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe
);
  localparam int LIM = 20 * QTR;
  reg [7:0] txw_q;
  reg [7:0] own_q;
  reg ord_q;
  reg ordw_q;
  reg mt_q;
  wire [7:0] txw_rev = {<<{txw_q}};
  // ******
  // Shadow of what software wrote
  // ******
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      txw_q <= 8'hff;
      own_q <= 8'h00;
      ord_q <= 1'b0;
      ordw_q <= 1'b0;
      mt_q <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `TWS_OFS_TXHOLD:
        begin
          txw_q <= reg_wdata;
          ordw_q <= ord_q;
        end
        `TWS_OFS_OWNADR: own_q <= reg_wdata;
        `TWS_OFS_MODE: ord_q <= reg_wdata[`TWS_MODE_ORDER];
        `TWS_OFS_CTRL1: mt_q <= reg_wdata[`TWS_C1_MASTER] & reg_wdata[`TWS_C1_TRANSMIT];
        default: ;
      endcase
    end
  end
  // ******
  // Properties
  // ******
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);
  // Data edges with the clock line high are the only framing marks
  sequence s_start;
    $rose(sda_oe) && !scl_oe && scl_in;
  endsequence
  sequence s_stop;
    $fell(sda_oe) && !scl_oe && scl_in;
  endsequence
  sequence s_go;
    reg_wr && reg_addr == `TWS_OFS_CTRL2 && reg_wdata == 8'h80 && mt_q && !own_q[0] && scl_in && sda_in;
  endsequence
  chk_start_form: assert property (s_start |-> ##[1:LIM] $rose(scl_oe))
    else $error("start not followed by clock low");
  chk_stop_form: assert property (s_stop |-> !scl_oe [*8])
    else $error("clock pulled after stop");
  chk_start_issue: assert property (s_go |-> ##[1:LIM] $rose(sda_oe))
    else $error("no start after busy write");
  chk_tx_readback: assert property ($past(reg_rd) && $past(reg_addr) == `TWS_OFS_TXHOLD
    |-> reg_rdata == (ordw_q ? txw_rev : txw_q)) else $error("transmit holding readback wrong");
  chk_own_readback: assert property ($past(reg_rd) && $past(reg_addr) == `TWS_OFS_OWNADR
    |-> reg_rdata == own_q) else $error("own address readback wrong");
  chk_rd_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  chk_oe_reset: assert property ($fell(srst) |-> !scl_oe && !sda_oe)
    else $error("pins driven after reset");
  chk_scl_high: assert property ($fell(scl_oe) |-> !scl_oe [*2])
    else $error("clock high phase too short");
  // Open drain: the pin value is always low, only the enable moves
  chk_od_low: assert property (!scl_out && !sda_out)
    else $error("pin output value not low");
  cover property (s_start);
endmodule // tws_chk

bind tws_core tws_chk #(.QTR(QTR)) u_chk
(
  .core_clk(core_clk),
  .srst(srst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .scl_in(scl_in),
  .scl_out(scl_out),
  .scl_oe(scl_oe),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe(sda_oe)
);

// file: tws_peer.sv
// Far side of the bus: an acking slave listener and a frame-sending master.
// Assumes pulled-up open-drain wires; as master it clocks at 400 ns a bit.
`timescale 1ns/1ps
module tws_peer
(
  input wire scl,
  input wire sda,
  output reg scl_oe,
  output reg sda_oe
);
  reg ack_en = 1'b1;
  reg mst_mode = 1'b0;
  reg [7:0] got_q = 8'h00;
  reg [7:0] sh = 8'h00;
  integer got_cnt = 0;
  integer starts = 0;
  integer i;
  integer j;
  // Lines released at time zero, pull-ups give high
  initial
  begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  // Listener: acks whole bytes while not mastering, until a stop
  always
  begin
    @(negedge sda iff (scl === 1'b1));
    starts = starts + 1;
    fork : frame
      forever
      begin
        for (i = 0; i < 8; i = i + 1)
        begin
          @(posedge scl);
          sh = {sh[6:0], sda};
        end
        @(negedge scl);
        got_q = sh;
        got_cnt = got_cnt + 1;
        if (!mst_mode)
          sda_oe = ack_en;
        @(negedge scl);
        if (!mst_mode)
          sda_oe = 1'b0;
      end
      @(posedge sda iff (scl === 1'b1));
    join_any
    disable frame;
  end
  // One address frame with start and stop; honours a stretched clock
  task send_frame(input [7:0] b, output ack);
  begin
    mst_mode = 1'b1;
    sda_oe = 1'b1;
    #200 scl_oe = 1'b1;
    for (j = 0; j < 9; j = j + 1)
    begin
      #100 sda_oe = (j < 8) ? ~b[7 - j] : 1'b0;
      #100 scl_oe = 1'b0;
      wait (scl === 1'b1);
      #100 ack = sda;
      #100 scl_oe = 1'b1;
    end
    #100 sda_oe = 1'b1;
    #100 scl_oe = 1'b0;
    #200 sda_oe = 1'b0;
    #400 mst_mode = 1'b0;
  end
  endtask
endmodule // tws_peer

// file: two_wire_serial_master_slave_tb.sv
// Bench for tws_core: master transmit, no-ack, slave match, registers.
// Assumes tws_peer on pulled-up wires; quarter bit shortened to 2 cycles.
`timescale 1ns/1ps
`include "tws_defines.vh"
module two_wire_serial_master_slave_tb;
  reg core_clk = 1'b0;
  reg srst = 1'b1;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [7:0] reg_rdata;
  wire scl_oe, sda_oe, p_scl_oe, p_sda_oe;
  wire scl_w = ~(scl_oe | p_scl_oe);
  wire sda_w = ~(sda_oe | p_sda_oe);
  integer num_errors = 0;
  integer cmp_count = 0;
  reg [7:0] rv;
  reg ack;
  // 20 MHz core clock
  always #25 core_clk = ~core_clk;
  tws_core #(.QTR(8'd2)) dut
  (
    .core_clk(core_clk),
    .srst(srst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .scl_in(scl_w),
    .scl_out(),
    .scl_oe(scl_oe),
    .sda_in(sda_w),
    .sda_out(),
    .sda_oe(sda_oe)
  );
  tws_peer peer
  (
    .scl(scl_w),
    .sda(sda_w),
    .scl_oe(p_scl_oe),
    .sda_oe(p_sda_oe)
  );
  // ******
  // Register port tasks
  // ******
  task wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  end
  endtask
  // Answer is taken in the one cycle it stands
  task rd(input [3:0] a, output [7:0] d);
  begin
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  end
  endtask
  task chk(input string n, input [7:0] seen, input [7:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  end
  endtask
  task rc(input string n, input [3:0] a, input [7:0] m, input [7:0] e);
  begin
    rd(a, rv);
    chk(n, rv & m, e);
  end
  endtask
  // Bounded poll of one status bit; a timeout shows as a mismatch
  task poll(input string n, input [3:0] a, input integer b);
  integer k;
  begin
    k = 0;
    rd(a, rv);
    while (rv[b] !== 1'b1 && k < 300)
    begin
      rd(a, rv);
      k = k + 1;
    end
    chk(n, {7'h00, rv[b]}, 8'h01);
  end
  endtask
  task results;
  begin
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // Watchdog, well beyond the under a thousand cycles the tests need
  initial
  begin
    #1000000;
    num_errors = num_errors + 1;
    $display("ERROR watchdog expected done seen hang");
    results;
  end
  // ******
  // Tests
  // ******
  initial
  begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    rc("tx reset", `TWS_OFS_TXHOLD, 8'hff, 8'hff);
    rc("rx reset", `TWS_OFS_RXHOLD, 8'hff, 8'hff);
    rc("own reset", `TWS_OFS_OWNADR, 8'hff, 8'h00);
    wr(`TWS_OFS_RXHOLD, 8'h12);
    rc("rx write", `TWS_OFS_RXHOLD, 8'hff, 8'hff);
    rc("unmapped", 4'h9, 8'hff, 8'h00);
    wr(`TWS_OFS_OWNADR, 8'h84);
    rc("own rw", `TWS_OFS_OWNADR, 8'hff, 8'h84);
    $display("Test reset values done");
    // Two bytes back to back, then the clock waits low until stop
    wr(`TWS_OFS_CTRL1, 8'hb0);
    wr(`TWS_OFS_CTRL2, 8'h80);
    poll("txe", `TWS_OFS_STATUS, `TWS_ST_TXE);
    wr(`TWS_OFS_TXHOLD, 8'ha6);
    poll("txe refill", `TWS_OFS_STATUS, `TWS_ST_TXE);
    rc("busy", `TWS_OFS_CTRL2, 8'h80, 8'h80);
    wr(`TWS_OFS_TXHOLD, 8'h5a);
    poll("tx_end_flag", `TWS_OFS_STATUS, `TWS_ST_TX_END_FLAG);
    chk("bytes", peer.got_cnt[7:0], 8'h02);
    chk("last byte", peer.got_q, 8'h5a);
    rc("ack bit", `TWS_OFS_IRQEN, 8'h02, 8'h00);
    repeat (40) @(posedge core_clk);
    chk("clock held", {7'h00, scl_w}, 8'h00);
    wr(`TWS_OFS_CTRL2, 8'h00);
    poll("stop", `TWS_OFS_STATUS, `TWS_ST_STOP);
    rc("slave mode", `TWS_OFS_CTRL1, 8'h30, 8'h00);
    rc("bus free", `TWS_OFS_CTRL2, 8'h80, 8'h00);
    chk("starts", peer.starts[7:0], 8'h01);
    wr(`TWS_OFS_STATUS, 8'h00);
    $display("Test master transmit done");
    // Slave refuses the byte while acknowledge checking is on
    peer.ack_en = 1'b0;
    wr(`TWS_OFS_IRQEN, 8'h01);
    wr(`TWS_OFS_CTRL1, 8'hb0);
    wr(`TWS_OFS_CTRL2, 8'h80);
    poll("txe", `TWS_OFS_STATUS, `TWS_ST_TXE);
    wr(`TWS_OFS_TXHOLD, 8'ha6);
    poll("nack", `TWS_OFS_STATUS, `TWS_ST_NACK);
    rc("ack bit", `TWS_OFS_IRQEN, 8'h02, 8'h02);
    wr(`TWS_OFS_CTRL2, 8'h00);
    poll("stop", `TWS_OFS_STATUS, `TWS_ST_STOP);
    peer.ack_en = 1'b1;
    wr(`TWS_OFS_STATUS, 8'h00);
    wr(`TWS_OFS_IRQEN, 8'h00);
    $display("Test no acknowledge done");
    // Slave receive: general call, mismatch, own address
    wr(`TWS_OFS_CTRL1, 8'h80);
    peer.send_frame(8'h00, ack);
    wr(`TWS_OFS_STATUS, 8'h00);
    rc("gcall", `TWS_OFS_STATUS, 8'h03, 8'h03);
    wr(`TWS_OFS_STATUS, 8'h00);
    rc("cleared", `TWS_OFS_STATUS, 8'h03, 8'h00);
    peer.send_frame(8'h86, ack);
    rc("no match", `TWS_OFS_STATUS, 8'h03, 8'h00);
    peer.send_frame(8'h84, ack);
    chk("slave ack", {7'h00, ack}, 8'h00);
    rc("match", `TWS_OFS_STATUS, 8'h23, 8'h22);
    rc("rx byte", `TWS_OFS_RXHOLD, 8'hff, 8'h84);
    $display("Test slave address done");
    // Bit-order select on transmit holding readback
    wr(`TWS_OFS_MODE, 8'h80);
    wr(`TWS_OFS_TXHOLD, 8'h01);
    rc("reversed", `TWS_OFS_TXHOLD, 8'hff, 8'h80);
    wr(`TWS_OFS_MODE, 8'h00);
    wr(`TWS_OFS_TXHOLD, 8'h3c);
    rc("plain", `TWS_OFS_TXHOLD, 8'hff, 8'h3c);
    $display("Test bit order done");
    results;
  end
endmodule // two_wire_serial_master_slave_tb
